/* hbridge_pkg.sv */
// Purpose: shared constants and types for the h-bridge serial control port
// Assumes: sys_clk at 50 MHz; 16-bit command and response words
// Notes:   field layout of the command word is fixed here for all files
// How it works
// (R1) sample serial input on falling clock edges
// (R2) update serial output on rising clock edges
// (R3) response word leaves most significant bit first
// (R4) after sixteen bits, echo input to output
// (R5) serial output undriven unless chip select low
// (R6) master sends words most significant bit first
// (R7) input only taken while chip select low
// (R8) chip select rise commits shifted word as command
// (R9) chip select fall loads previously addressed register
// (R10) daisy chain: words pass through sixteen-bit delay
// (R11) wake low: all switches off, sleep
// (R12) wake high: normal operation enabled
// (R13) disable high: all switches off, standby
// (R14) disable low does not inhibit outputs
// (R15) never both switches on in one half
// (R16) direction input high steers its half to the high side, low to the low side
// (R17) direction change passes through dead time
// (R18) switching timing follows programmed slew setting
// (R19) fault flag low on any unmasked fault
// (R20) sleep takes priority over standby
package hbridge_pkg;
    // word geometry
    localparam int WORD_BITS          = 16;
    localparam int ADDR_MSB           = 15;
    localparam int ADDR_LSB           = 14;
    localparam int WRITE_BIT          = 13;
    localparam int DATA_MSB           = 7;
    localparam int SLEW_MSB           = 2;
    localparam logic [4:0] COUNT_FULL = 5'h10;

    // register addresses carried in the command word
    localparam logic [1:0] ADDR_STATUS = 2'h0;
    localparam logic [1:0] ADDR_MASK   = 2'h1;
    localparam logic [1:0] ADDR_CONFIG = 2'h2;
    localparam logic [1:0] ADDR_STATE  = 2'h3;

    // reset values
    localparam logic [7:0]  MASK_RESET   = 8'hFF;
    localparam logic [7:0]  CONFIG_RESET = 8'h03;
    localparam logic [15:0] CMD_RESET    = 16'h0000;

    // timing: one slew step of dead time, rounded up to whole cycles
    localparam int SYS_CLK_PERIOD_NS = 20;
    localparam int DEAD_TIME_NS      = 200;
    localparam int DEAD_CYCLES       =
        (DEAD_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam logic [6:0] DEAD_STEP = 7'(DEAD_CYCLES);

    // half-bridge switch state
    typedef enum logic [2:0] {
        HB_OFF  = 3'b001,
        HB_HIGH = 3'b010,
        HB_LOW  = 3'b100
    } hb_state_t;
endpackage : hbridge_pkg

/* half_bridge_drive.sv */
// Purpose: one half-bridge, high or low switch with dead time between
// Assumes: want_high and enable already on sys_clk
// Notes:   any re-enable also waits out the dead time, on purpose
module half_bridge_drive (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // control
    input  wire logic       enable,
    input  wire logic       want_high,
    input  wire logic [6:0] dead_cycles,
    // switch drives
    output logic            high_on,
    output logic            low_on
);
    hbridge_pkg::hb_state_t state_reg;
    hbridge_pkg::hb_state_t state_next;
    logic [6:0]             cnt_reg;
    logic [6:0]             cnt_next;

    // next state: every change of side goes through off
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        unique case (state_reg)
            hbridge_pkg::HB_OFF: begin
                if (cnt_reg < dead_cycles) begin
                    cnt_next = cnt_reg + 7'h01; // R17 R18
                end else if (enable) begin
                    state_next = want_high ? hbridge_pkg::HB_HIGH
                                           : hbridge_pkg::HB_LOW; // R16
                end
            end
            hbridge_pkg::HB_HIGH: begin
                if (!enable || !want_high) begin
                    state_next = hbridge_pkg::HB_OFF; // R15
                    cnt_next   = 7'h00;
                end
            end
            hbridge_pkg::HB_LOW: begin
                if (!enable || want_high) begin
                    state_next = hbridge_pkg::HB_OFF; // R15
                    cnt_next   = 7'h00;
                end
            end
            default: begin
                state_next = hbridge_pkg::HB_OFF;
                cnt_next   = 7'h00;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= hbridge_pkg::HB_OFF;
            cnt_reg   <= 7'h00;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // drives are state bits, so both can never be high together
    assign high_on = state_reg[1];
    assign low_on  = state_reg[2];

    a_no_overlap: assert property (@(posedge sys_clk) disable iff (rst) // R15
        !(high_on && low_on)) else $error("both switches on");
    a_gap_to_low: assert property (@(posedge sys_clk) disable iff (rst) // R17
        $fell(high_on) |-> !low_on [*8]) else $error("no gap before low");
    a_gap_to_high: assert property (@(posedge sys_clk) disable iff (rst) // R17
        $fell(low_on) |-> !high_on [*8]) else $error("no gap before high");
endmodule : half_bridge_drive

/* spi_link.sv */
// Purpose: serial shifter on the link clock, loads, shifts and echoes
// Assumes: resp_word is held steady by the system side during a frame
// Notes:   shift_word and bit_count stay valid after the frame ends
module spi_link (
    // link clock and frame reset
    input  wire logic        sclk,
    input  wire logic        rst,
    input  wire logic        frame_rst,
    // serial data
    input  wire logic        mosi,
    output logic             miso_bit,
    // system side words
    input  wire logic [15:0] resp_word,
    output logic [15:0]      shift_word,
    output logic             word_full
);
    logic        first_reg;
    logic        first_next;
    logic [15:0] shift_reg;
    logic [15:0] shift_next;
    logic [4:0]  count_reg;
    logic [4:0]  count_next;
    logic        miso_reg;
    logic        miso_next;

    // falling edge: the first edge of a frame takes the response word in
    always_comb begin
        first_next = 1'b0;
        shift_next = {first_reg ? resp_word[14:0] : shift_reg[14:0],
                      mosi}; // R1 R9
        count_next = first_reg ? 5'h01 : count_reg;
        if (!first_reg && count_reg != hbridge_pkg::COUNT_FULL) begin
            count_next = count_reg + 5'h01;
        end
    end

    // frame_rst holds first set while chip select is high
    always_ff @(negedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            first_reg <= 1'b1; // R7
        end else begin
            first_reg <= first_next;
        end
    end

    // shift and count survive the frame end for the commit
    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            shift_reg <= 16'h0000;
            count_reg <= 5'h00;
        end else if (!first_reg || !frame_rst) begin
            shift_reg <= shift_next;
            count_reg <= count_next;
        end
    end

    // rising edge: msb first, later bits come from the top of the shift register
    always_comb begin
        miso_next = first_reg ? resp_word[15] : shift_reg[15]; // R2 R3 R4 R10
    end

    always_ff @(posedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            miso_reg <= 1'b0;
        end else begin
            miso_reg <= miso_next;
        end
    end

    assign miso_bit   = miso_reg;
    assign shift_word = shift_reg;
    assign word_full  = (count_reg == hbridge_pkg::COUNT_FULL);

    a_msb_first: assert property (@(posedge sclk) disable iff (frame_rst) // R3
        first_reg |=> miso_bit == $past(resp_word[15]))
        else $error("first bit not msb");
    a_echo_input: assert property (@(negedge sclk) // R4
        disable iff (frame_rst)
        (!first_reg && count_reg == hbridge_pkg::COUNT_FULL)
        |-> shift_reg[15] == $past(mosi, 16))
        else $error("echo not sixteen bits late");
endmodule : spi_link

/* hbridge_spi_control_port.sv */
// Purpose: control front end of an h-bridge driver with a serial port
// Assumes: sys_clk 50 MHz; sclk stops outside frames; fault_in on sys_clk
// Notes:   miso enable follows synchronised chip select, a few cycles late
module hbridge_spi_control_port (
    // system
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // serial link
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       mosi,
    output logic            miso_o,
    output logic            miso_oe,
    // mode and direction pins
    input  wire logic       wake_input,
    input  wire logic       output_disable_input,
    input  wire logic       direction_input_a,
    input  wire logic       direction_input_b,
    // protection fault sources
    input  wire logic [7:0] fault_in,
    // switch drives
    output logic            bridge_output_a_high_on,
    output logic            bridge_output_a_low_on,
    output logic            bridge_output_b_high_on,
    output logic            bridge_output_b_low_on,
    // state
    output logic            sleep_state,
    output logic            standby_state,
    output logic [2:0]      slew_sel,
    // open-drain fault flag
    output logic            fault_flag_n_o,
    output logic            fault_flag_n_oe
);
    // synchronised pins: cs_n, wake, disable, dir a, dir b
    logic [4:0]  pin_meta_reg;
    logic [4:0]  pin_meta_next;
    logic [4:0]  pin_sync_reg;
    logic [4:0]  pin_sync_next;
    logic        cs_prev_reg;
    logic        cs_prev_next;
    logic        cs_s;
    logic        wake_s;
    logic        dis_s;
    logic        cs_rise;

    // command and settings
    logic [15:0] cmd_reg;
    logic [15:0] cmd_next;
    logic [1:0]  resp_addr_reg;
    logic [1:0]  resp_addr_next;
    logic [7:0]  mask_reg;
    logic [7:0]  mask_next;
    logic [7:0]  config_reg;
    logic [7:0]  config_next;
    logic [7:0]  status_reg;
    logic [7:0]  status_next;
    logic [7:0]  status_clear;
    logic [15:0] resp_reg;
    logic [15:0] resp_next;

    // bridge and outputs
    logic        sleep_reg;
    logic        sleep_next;
    logic        standby_reg;
    logic        standby_next;
    logic [6:0]  dead_reg;
    logic [6:0]  dead_next;
    logic [2:0]  slew_reg;
    logic [2:0]  slew_next;
    logic        fault_oe_reg;
    logic        fault_oe_next;
    logic        fault_o_reg;
    logic        fault_o_next;
    logic        miso_oe_reg;
    logic        miso_oe_next;
    logic        bridge_enable;

    // link domain
    logic        frame_rst;
    logic [15:0] link_word;
    logic        link_full;

    // chip select high clears the frame state in the link domain
    assign frame_rst = rst | cs_n; // R7

    spi_link u_link (
        .sclk       (sclk),
        .rst        (rst),
        .frame_rst  (frame_rst),
        .mosi       (mosi),
        .miso_bit   (miso_o),
        .resp_word  (resp_reg),
        .shift_word (link_word),
        .word_full  (link_full)
    );

    // two-flop synchronisers for every pin read on sys_clk
    always_comb begin
        pin_meta_next = {cs_n, wake_input, output_disable_input,
                         direction_input_a, direction_input_b};
        pin_sync_next = pin_meta_reg;
        cs_prev_next  = pin_sync_reg[4];
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_meta_reg <= 5'h10; // wake low: asleep until pins arrive
            pin_sync_reg <= 5'h10;
            cs_prev_reg  <= 1'b1;
        end else begin
            pin_meta_reg <= pin_meta_next;
            pin_sync_reg <= pin_sync_next;
            cs_prev_reg  <= cs_prev_next;
        end
    end

    assign cs_s    = pin_sync_reg[4];
    assign wake_s  = pin_sync_reg[3];
    assign dis_s   = pin_sync_reg[2];
    assign cs_rise = cs_s & ~cs_prev_reg;

    // commit on chip select rise; link word is quiet once sclk has stopped
    always_comb begin
        cmd_next       = cmd_reg;
        resp_addr_next = resp_addr_reg;
        mask_next      = mask_reg;
        config_next    = config_reg;
        status_clear   = 8'h00;
        if (cs_rise && link_full) begin
            cmd_next       = link_word; // R8
            resp_addr_next = link_word[hbridge_pkg::ADDR_MSB:
                                       hbridge_pkg::ADDR_LSB];
            if (resp_addr_reg == hbridge_pkg::ADDR_STATUS) begin
                status_clear = resp_reg[7:0];
            end
            if (link_word[hbridge_pkg::WRITE_BIT]) begin
                unique case (link_word[hbridge_pkg::ADDR_MSB:
                                       hbridge_pkg::ADDR_LSB])
                    hbridge_pkg::ADDR_MASK: begin
                        mask_next = link_word[hbridge_pkg::DATA_MSB:0];
                    end
                    hbridge_pkg::ADDR_CONFIG: begin
                        config_next = link_word[hbridge_pkg::DATA_MSB:0];
                    end
                    hbridge_pkg::ADDR_STATUS,
                    hbridge_pkg::ADDR_STATE: begin
                        mask_next = mask_reg;
                    end
                endcase
            end
        end
        // a fault that arrives with the clear stays latched
        status_next = (status_reg & ~status_clear) | fault_in;
    end

    // response word only moves while idle, so a frame shifts a stable word
    always_comb begin
        resp_next = resp_reg;
        if (cs_s && cs_prev_reg) begin
            unique case (resp_addr_reg) // R9
                hbridge_pkg::ADDR_STATUS: resp_next = {8'h00, status_reg};
                hbridge_pkg::ADDR_MASK:   resp_next = {8'h00, mask_reg};
                hbridge_pkg::ADDR_CONFIG: resp_next = {8'h00, config_reg};
                hbridge_pkg::ADDR_STATE:  resp_next = {12'h000, sleep_reg,
                                              standby_reg, pin_sync_reg[1:0]};
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cmd_reg       <= hbridge_pkg::CMD_RESET;
            resp_addr_reg <= hbridge_pkg::ADDR_STATUS;
            mask_reg      <= hbridge_pkg::MASK_RESET;
            config_reg    <= hbridge_pkg::CONFIG_RESET;
            status_reg    <= 8'h00;
            resp_reg      <= 16'h0000;
        end else begin
            cmd_reg       <= cmd_next;
            resp_addr_reg <= resp_addr_next;
            mask_reg      <= mask_next;
            config_reg    <= config_next;
            status_reg    <= status_next;
            resp_reg      <= resp_next;
        end
    end

    // modes, slew timing and pin drives
    always_comb begin
        sleep_next    = ~wake_s; // R11 R12
        standby_next  = wake_s & dis_s; // R13 R14 R20
        slew_next     = config_reg[hbridge_pkg::SLEW_MSB:0];
        dead_next     = 7'(({4'h0, config_reg[hbridge_pkg::SLEW_MSB:0]}
                           + 7'h01) * hbridge_pkg::DEAD_STEP); // R18
        fault_oe_next = |(status_reg & mask_reg); // R19
        fault_o_next  = 1'b0;
        miso_oe_next  = ~cs_s; // R5
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sleep_reg    <= 1'b1;
            standby_reg  <= 1'b0;
            slew_reg     <= 3'h0;
            dead_reg     <= hbridge_pkg::DEAD_STEP;
            fault_oe_reg <= 1'b0;
            fault_o_reg  <= 1'b0;
            miso_oe_reg  <= 1'b0;
        end else begin
            sleep_reg    <= sleep_next;
            standby_reg  <= standby_next;
            slew_reg     <= slew_next;
            dead_reg     <= dead_next;
            fault_oe_reg <= fault_oe_next;
            fault_o_reg  <= fault_o_next;
            miso_oe_reg  <= miso_oe_next;
        end
    end

    // either mode forces all four switches off
    assign bridge_enable = ~sleep_reg & ~standby_reg; // R11 R13

    half_bridge_drive u_half_a (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .enable      (bridge_enable),
        .want_high   (pin_sync_reg[1]),
        .dead_cycles (dead_reg),
        .high_on     (bridge_output_a_high_on),
        .low_on      (bridge_output_a_low_on)
    );

    half_bridge_drive u_half_b (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .enable      (bridge_enable),
        .want_high   (pin_sync_reg[0]),
        .dead_cycles (dead_reg),
        .high_on     (bridge_output_b_high_on),
        .low_on      (bridge_output_b_low_on)
    );

    assign sleep_state     = sleep_reg;
    assign standby_state   = standby_reg;
    assign slew_sel        = slew_reg;
    assign fault_flag_n_o  = fault_o_reg;
    assign fault_flag_n_oe = fault_oe_reg;
    assign miso_oe         = miso_oe_reg;

    // all four switches are off
    sequence all_off_s;
        !bridge_output_a_high_on && !bridge_output_a_low_on &&
        !bridge_output_b_high_on && !bridge_output_b_low_on;
    endsequence

    // wake held low for two cycles
    sequence wake_low_s;
        !wake_s ##1 !wake_s;
    endsequence

    // a commit is the synchronised chip select rise of a full word
    sequence commit_s;
        cs_rise && link_full;
    endsequence

    a_sleep_off: assert property (@(posedge sys_clk) disable iff (rst) // R11
        wake_low_s |=> all_off_s) else $error("switch on in sleep");
    a_standby_off: assert property (@(posedge sys_clk) disable iff (rst) // R13
        (wake_s && dis_s) ##1 (wake_s && dis_s)
        |=> (all_off_s and !sleep_reg)) else $error("switch on in standby");
    a_sleep_first: assert property (@(posedge sys_clk) disable iff (rst) // R20
        (!wake_s && dis_s) |=> sleep_reg && !standby_reg)
        else $error("standby beat sleep");
    a_normal_run: assert property (@(posedge sys_clk) // R12 R14
        disable iff (rst) (wake_s && !dis_s) |=> bridge_enable)
        else $error("bridge inhibited");
    a_miso_idle: assert property (@(posedge sys_clk) disable iff (rst) // R5
        cs_s |=> !miso_oe) else $error("miso driven while idle");
    a_cmd_commit: assert property (@(posedge sys_clk) disable iff (rst) // R8
        commit_s |=> cmd_reg == $past(link_word))
        else $error("command not committed");
    a_slew_dead: assert property (@(posedge sys_clk) disable iff (rst) // R18
        (config_reg[2:0] == 3'h7) ##1 $stable(config_reg)
        |-> dead_reg == 7'h50) else $error("dead time off slew");
    a_fault_flag: assert property (@(posedge sys_clk) disable iff (rst) // R19
        (fault_in != 8'h00 && (fault_in & mask_reg) != 8'h00)
        ##1 $stable(mask_reg) |=> fault_flag_n_oe)
        else $error("unmasked fault not flagged");
    a_fault_quiet: assert property (@(posedge sys_clk) disable iff (rst) // R19
        ((status_reg & mask_reg) == 8'h00) |=> !fault_flag_n_oe)
        else $error("flag without fault");

    // writes land at the commit, and a new fault always latches
    a_mask_write: assert property (@(posedge sys_clk) disable iff (rst) // R8
        commit_s ##0 (link_word[15:13] == 3'h3)
        |=> mask_reg == $past(link_word[7:0]))
        else $error("mask not written");
    a_config_write: assert property (@(posedge sys_clk) disable iff (rst) // R8
        commit_s ##0 (link_word[15:13] == 3'h5)
        |=> config_reg == $past(link_word[7:0]))
        else $error("config not written");
    a_resp_hold: assert property (@(posedge sys_clk) disable iff (rst) // R9
        !cs_s |=> $stable(resp_reg)) else $error("response moved in frame");
    a_status_set: assert property (@(posedge sys_clk) disable iff (rst) // R19
        (fault_in != 8'h00) |=> (status_reg & $past(fault_in)) == $past(fault_in))
        else $error("fault not latched");
endmodule : hbridge_spi_control_port

/* spi_host_model.sv */
// Purpose: host side of the serial link, mode 1, 16-bit words
// Assumes: link clock of 125 ns made here, only inside frames
// Notes:   a released line shows the inverse of its last value
module spi_host_model (
    // link lines driven by the host
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    // answer from the device
    input  wire logic miso_o,
    input  wire logic miso_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic last_bit;

    // idle link: clock low and still, select high
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        last_bit = 1'b0;
    end

    // one frame of nb bits; longer frames pass words down a chain
    task automatic xfer(input logic [31:0] tx, input int nb,
                        output logic [31:0] rx);
        logic b;
        rx = 32'h0;
        #7.3; // odd offset keeps the link phase unrelated to sys_clk
        cs_n = 1'b0;
        #100;
        for (int i = nb - 1; i >= 0; i--) begin
            sclk = 1'b1;
            mosi = tx[i];
            #62.5;
            sclk = 1'b0;
            b = miso_oe ? miso_o : ~last_bit;
            last_bit = b;
            rx = {rx[30:0], b};
            #62.5;
        end
        #100;
        cs_n = 1'b1;
        mosi = ~mosi; // no stale level once released
        #400;
    endtask : xfer
endmodule : spi_host_model

/* testbench.sv */
// Purpose: self-checking bench for the h-bridge serial control port
// Assumes: sys_clk 20 ns, link clock 125 ns from the host model
// Notes:   dead time is judged with a two-cycle tolerance
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        wake = 1'b0;
    logic        dis = 1'b0;
    logic        dir_a = 1'b1;
    logic        dir_b = 1'b0;
    logic [7:0]  fault_in = 8'h00;
    logic        a_hi, a_lo, b_hi, b_lo;
    logic        sleep_s, standby_s, miso_o, miso_oe, ff_o, ff_oe;
    logic [2:0]  slew_sel;
    logic [31:0] rx;
    wire         sclk, cs_n, mosi;
    int          fails = 0;
    int          n_tests = 0;

    // free-running system clock
    always #10 sys_clk = ~sys_clk;

    spi_host_model host_u (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso_o(miso_o), .miso_oe(miso_oe));

    hbridge_spi_control_port dut_u (.sys_clk(sys_clk), .rst(rst),
        .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso_o(miso_o),
        .miso_oe(miso_oe), .wake_input(wake),
        .output_disable_input(dis), .direction_input_a(dir_a),
        .direction_input_b(dir_b), .fault_in(fault_in),
        .bridge_output_a_high_on(a_hi), .bridge_output_a_low_on(a_lo),
        .bridge_output_b_high_on(b_hi), .bridge_output_b_low_on(b_lo),
        .sleep_state(sleep_s), .standby_state(standby_s),
        .slew_sel(slew_sel), .fault_flag_n_o(ff_o),
        .fault_flag_n_oe(ff_oe));

    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    // one host frame, then room for the commit and the reload
    task automatic frame(input logic [31:0] tx, input int nb);
        host_u.xfer(tx, nb, rx);
        cyc(8);
        #1;
    endtask : frame

    // a half bridge never has both switches on, checked every edge
    always @(posedge sys_clk) begin
        if (rst === 1'b0 && ((a_hi & a_lo) | (b_hi & b_lo)) !== 1'b0) begin
            check("shoot_through", 16'h1, 16'h0);
        end
    end

    // every wake and disable combination, bridge steered a high and b low
    task automatic t_modes;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            wake <= i[1];
            dis <= i[0];
            cyc(70);
            #1;
            check("sleep", {15'h0, sleep_s}, {15'h0, ~i[1]});
            check("standby", {15'h0, standby_s},
                  {15'h0, i[1] & i[0]});
            check("switches", {12'h0, a_hi, a_lo, b_hi, b_lo},
                  (i == 2) ? 16'h0009 : 16'h0000);
        end
        @(posedge sys_clk);
        dis <= 1'b0;
        cyc(70);
    endtask : t_modes

    // flip a and count cycles with both switches of a off
    task automatic t_dead(input logic [2:0] s);
        int n;
        int d;
        int k;
        logic tgt;
        n = 0;
        d = (s + 1) * 10 + 1;
        tgt = ~dir_a;
        @(posedge sys_clk);
        dir_a <= tgt;
        for (k = 0; k < 200; k++) begin
            @(posedge sys_clk);
            #1;
            if ((tgt ? a_hi : a_lo) === 1'b1) break;
            if (!(a_hi | a_lo)) n++;
        end
        if (k == 200) begin
            check("dead_timeout", 16'h1, 16'h0);
            print_verdict();
        end else begin
            check("slew", {13'h0, slew_sel}, {13'h0, s});
            check("dead_ok", {15'h0, n >= d - 2 && n <= d + 2}, 16'h1);
        end
    endtask : t_dead

    // write, read back, chain echo, short frame refused
    task automatic t_spi;
        frame(32'h0000A005, 16);
        check("resp_status", rx[15:0], 16'h0000);
        check("slew_write", {13'h0, slew_sel}, 16'h0005);
        check("miso_idle", {15'h0, miso_oe}, 16'h0000);
        frame(32'h00008000, 16);
        check("resp_config", rx[15:0], 16'h0005);
        frame(32'h12348000, 32);
        check("resp_first", rx[31:16], 16'h0005);
        check("echo", rx[15:0], 16'h1234);
        frame(32'h000000A0, 8);
        check("short_frame", {13'h0, slew_sel}, 16'h0005);
    endtask : t_spi

    // sticky fault drives the flag, a status read clears it, mask hides it
    task automatic t_fault;
        @(posedge sys_clk);
        fault_in <= 8'h04;
        @(posedge sys_clk);
        fault_in <= 8'h00;
        cyc(4);
        #1;
        check("flag_on", {14'h0, ff_oe, ff_o}, 16'h0002);
        frame(32'h00000000, 16);
        frame(32'h00004000, 16);
        check("resp_fault", rx[15:0], 16'h0004);
        check("flag_off", {15'h0, ff_oe}, 16'h0000);
        frame(32'h00006000, 16);
        check("resp_mask", rx[15:0], 16'h00FF);
        @(posedge sys_clk);
        fault_in <= 8'h04;
        @(posedge sys_clk);
        fault_in <= 8'h00;
        cyc(4);
        #1;
        check("flag_masked", {15'h0, ff_oe}, 16'h0000);
    endtask : t_fault

    // main sequence: reset for two cycles, then each scenario
    initial begin
        @(posedge sys_clk);
        #1;
        check("rst_sleep", {15'h0, sleep_s}, 16'h0001);
        check("rst_sw", {12'h0, a_hi, a_lo, b_hi, b_lo}, 16'h0);
        @(posedge sys_clk);
        rst <= 1'b0;
        cyc(3);
        #1;
        check("rst_slew", {13'h0, slew_sel}, 16'h0003);
        t_modes();
        t_dead(3'h3);
        t_spi();
        t_dead(3'h5);
        frame(32'h0000A007, 16);
        check("resp_config_b", rx[15:0], 16'h0005);
        t_dead(3'h7);
        t_fault();
        print_verdict();
    end
endmodule : testbench
